// >>> hdl/adc_seq_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the ADC sequencer control block
// Assumes: 100 MHz clock, APB register access with 32-bit data
// Notes:   Times are in ns, cycle counts are derived from them
//////////////////////////////////////////////////////////////////////////////
package adc_seq_pkg;

  localparam int unsigned CLK_MHZ = 100;
  // Blanking step per code and one conversion time
  localparam int unsigned BLANK_STEP_NS = 500;
  localparam int unsigned CONV_NS = 2000;
  // Least times round up to whole cycles
  localparam int unsigned BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONVS_PER_GROUP = 3;

  localparam int CNT_W = 12;
  localparam int PER_W = 16;
  localparam int BLANK_W = 4;
  localparam int CHAN_W = 5;
  localparam int NUM_OUT = 24;

  localparam logic [PER_W-1:0] CONV_X3_CYC = PER_W'(CONVS_PER_GROUP * CONV_CYC);
  localparam logic [CNT_W-1:0] CONV_LAST_CNT = CNT_W'(CONV_CYC - 1);
  localparam logic [PER_W-1:0] PER_MAX = {PER_W{1'b1}};

  // Register byte offsets
  localparam logic [7:0] OFS_CHAN = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BLANK = 8'h0C;
  localparam logic [7:0] OFS_FCLR = 8'h10;

  // Status and fault clear bit positions
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int FCLR_BIT = 0;

  // Channel codes
  localparam logic [CHAN_W-1:0] CODE_MAX_SCAN = 5'h06;
  localparam logic [CHAN_W-1:0] CODE_RESERVED = 5'h07;
  localparam logic [CHAN_W-1:0] CODE_FIRST_OUT = 5'h08;

  localparam logic [2:0] LAST_GROUP = 3'h7;
  localparam logic [3:0] SCAN_MIN_PERIODS = 4'h9;
  localparam logic [7:0] RESULT_RESERVED = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEEK = 3'b001,
    S_ARM = 3'b011,
    S_BLANK = 3'b010,
    S_CONV = 3'b110,
    S_SCAN_WAIT = 3'b111,
    S_FINAL = 3'b101
  } state_e;

endpackage : adc_seq_pkg

// >>> hdl/adc_sequencer_control.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Channel select, conversion sequencing, blanking and max scan
// Assumes: Analog converter delivers conv_data after CONV_CYC cycles
// Notes:   Register map reached over APB, zero wait states
//
// Contract
// - Channel select write starts one conversion and clears done.
// - Finished conversion stores 8-bit result and sets done.
// - Result read clears done and restarts conversion on selected channel.
// - Codes 0-6 internal sources and scan, 7 reserved, 8-31 outputs.
// - Enabled output sampled after its on edge plus blanking delay.
// - Disabled output is sampled at once in its off state.
// - Code 06h runs auto-scan storing the highest output voltage.
// - Scan measures one three-output group per period, eight groups.
// - Scan result only valid after nine dimming periods.
// - After eight groups scan sets done and halts.
// - Result read clears done; scan restarts if code still 06h.
// - Channel select write in scan clears done and restarts.
// - Disabled outputs are skipped in scan.
// - Too short dimming period aborts and sets error; fault clear clears.
// - Outputs form eight groups of three, shifted by one eighth period.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module adc_sequencer_control (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [adc_seq_pkg::NUM_OUT-1:0] output_enable, // Per-output enable
  input wire logic [adc_seq_pkg::NUM_OUT-1:0] current_output, // Per-output on state
  input wire logic dim_period_start, // Pulse at each dimming period start
  input wire logic [7:0] conv_data, // Converter result
  output logic conv_sample, // Pulse at conversion start
  output logic [adc_seq_pkg::CHAN_W-1:0] conv_channel, // Analog mux code
  output logic adc_busy, // Sequencer active
  output logic conversion_done_flag, // Done flag
  output logic conversion_timing_error_flag // Timing error flag
);
  import adc_seq_pkg::*;

  typedef struct packed {
    state_e st;
    logic [CHAN_W-1:0] chan;
    logic [7:0] result;
    logic done;
    logic err;
    logic [BLANK_W-1:0] blank;
    logic [CNT_W-1:0] cnt;
    logic scan;
    logic [2:0] grp;
    logic [1:0] mem;
    logic [CHAN_W-1:0] sel;
    logic [7:0] maxv;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] per_len;
    logic per_valid;
    logic [3:0] per_seen;
    logic on_prev;
    logic wait_per;
    logic [31:0] prdata;
  } state_s;

  localparam state_s STATE_RST = '0;

  state_s s_q;
  state_s s_d;
  logic rd_result;
  logic wr_chan;
  logic wr_fclr;
  logic fin;
  logic rise;
  logic launch;
  logic [CHAN_W-1:0] code;
  logic [2:0] ge;
  logic [2:0] nm;
  logic [PER_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Blanking code to cycle count
  function automatic logic [CNT_W-1:0] blank_cyc(input logic [BLANK_W-1:0] c);
    blank_cyc = CNT_W'((int'(c) + 1) * BLANK_STEP_CYC);
  endfunction : blank_cyc

  // Enable bits of one group of three
  function automatic logic [2:0] group_en(input logic [NUM_OUT-1:0] en,
                                          input logic [2:0] g);
    logic [2:0] r;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      r[i] = en[int'(g) * 3 + i];
    end
    return r;
  endfunction : group_en

  // Lowest enabled member at or above start, with found bit on top
  function automatic logic [2:0] first_from(input logic [2:0] en3,
                                            input logic [2:0] start);
    logic [2:0] r;
    r = '0;
    for (int i = 2; i >= 0; i--) begin
      if (i >= int'(start) && en3[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : first_from

  // Read word for an address
  function automatic logic [31:0] rd_word(input logic [7:0] a, input state_s s);
    logic [31:0] r;
    r = '0;
    case (a)
      OFS_CHAN: r[CHAN_W-1:0] = s.chan;
      OFS_RESULT: r[7:0] = s.result;
      OFS_STATUS: begin
        r[ST_DONE_BIT] = s.done;
        r[ST_ERR_BIT] = s.err;
        r[ST_BUSY_BIT] = (s.st != S_IDLE);
      end
      OFS_BLANK: r[BLANK_W-1:0] = s.blank;
      default: r = '0;
    endcase
    return r;
  endfunction : rd_word

  // Offsets that answer without an error
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CHAN) || (a == OFS_RESULT) || (a == OFS_STATUS) ||
           (a == OFS_BLANK) || (a == OFS_FCLR);
  endfunction : mapped

  // Access phase of a transfer in one direction to one offset
  function automatic logic hit(input logic sel, input logic en, input logic dir,
                               input logic [7:0] a, input logic [7:0] ofs);
    return sel && en && dir && (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    rd_result = hit(psel, penable, ~pwrite, paddr, OFS_RESULT);
    wr_chan = hit(psel, penable, pwrite, paddr, OFS_CHAN);
    wr_fclr = hit(psel, penable, pwrite, paddr, OFS_FCLR);
    fin = 1'b0;
    launch = 1'b0;
    code = s_q.chan;
    ge = group_en(output_enable, s_q.grp);
    nm = '0;
    limit = PER_W'(blank_cyc(s_q.blank)) + CONV_X3_CYC;
    rise = 1'b0;
    // Internal codes leave sel past the last output, so no pin is looked at
    if (s_q.sel < CHAN_W'(NUM_OUT)) begin
      rise = current_output[s_q.sel] & ~s_q.on_prev;
      s_d.on_prev = current_output[s_q.sel];
    end

    // Dimming period measurement
    if (dim_period_start) begin
      s_d.per_len = (s_q.per_cnt == PER_MAX) ? PER_MAX : s_q.per_cnt + 1'b1;
      s_d.per_cnt = '0;
      s_d.per_valid = 1'b1;
      s_d.wait_per = 1'b0;
      if (s_q.scan && s_q.per_seen != SCAN_MIN_PERIODS) begin
        s_d.per_seen = s_q.per_seen + 1'b1;
      end
    end else if (s_q.per_cnt != PER_MAX) begin
      s_d.per_cnt = s_q.per_cnt + 1'b1;
    end

    case (s_q.st)
      S_IDLE: s_d.cnt = '0;
      S_SEEK: begin
        nm = first_from(ge, 3'h0);
        if (nm[2]) begin
          s_d.mem = nm[1:0];
          s_d.sel = CHAN_W'(int'(s_q.grp) * 3 + int'(nm[1:0]));
          s_d.on_prev = 1'b1;
          s_d.st = S_ARM;
        end else begin
          s_d.st = S_SCAN_WAIT;
        end
      end
      S_ARM: begin
        // During a scan a new group takes only an on edge of a later period
        if (rise && (!s_q.wait_per || dim_period_start)) begin
          s_d.cnt = '0;
          s_d.st = S_BLANK;
        end
      end
      S_BLANK: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == blank_cyc(s_q.blank) - 1'b1) begin
          s_d.cnt = '0;
          s_d.st = S_CONV;
        end
      end
      S_CONV: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == CONV_LAST_CNT) begin
          s_d.cnt = '0;
          if (s_q.scan) begin
            // Keep the largest reading of the scan
            if (conv_data > s_q.maxv) begin
              s_d.maxv = conv_data;
            end
            nm = first_from(ge, {1'b0, s_q.mem} + 3'h1);
            if (nm[2]) begin
              s_d.mem = nm[1:0];
              s_d.sel = CHAN_W'(int'(s_q.grp) * 3 + int'(nm[1:0]));
            end else if (s_q.grp == LAST_GROUP) begin
              s_d.st = S_FINAL;
            end else begin
              // Arm the next group at once so its edge in the next period is seen
              s_d.grp = s_q.grp + 1'b1;
              s_d.wait_per = 1'b1;
              s_d.st = S_SEEK;
            end
          end else begin
            s_d.result = conv_data;
            fin = 1'b1;
          end
        end
      end
      S_SCAN_WAIT: begin
        if (dim_period_start) begin
          if (s_q.grp == LAST_GROUP) begin
            s_d.st = S_FINAL;
          end else begin
            s_d.grp = s_q.grp + 1'b1;
            s_d.st = S_SEEK;
          end
        end
      end
      S_FINAL: begin
        // Hold the maximum until enough periods have passed
        if (s_q.per_seen == SCAN_MIN_PERIODS) begin
          s_d.result = s_q.maxv;
          fin = 1'b1;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    // Abort on a dimming period too short for blanking and three conversions
    if (s_q.st != S_IDLE && s_q.per_valid && s_q.per_len < limit) begin
      s_d.st = S_IDLE;
      s_d.scan = 1'b0;
      s_d.err = 1'b1;
      fin = 1'b0;
    end else if (wr_fclr && pwdata[FCLR_BIT]) begin
      s_d.err = 1'b0;
    end

    if (fin) begin
      s_d.done = 1'b1;
      s_d.scan = 1'b0;
      s_d.st = S_IDLE;
    end

    // Channel select write and result read; a finishing conversion wins
    if (wr_chan) begin
      s_d.chan = pwdata[CHAN_W-1:0];
      code = pwdata[CHAN_W-1:0];
    end
    launch = (wr_chan | rd_result) & ~fin;

    if (launch) begin
      s_d.done = 1'b0;
      s_d.cnt = '0;
      s_d.scan = 1'b0;
      s_d.wait_per = 1'b0;
      s_d.sel = code - CODE_FIRST_OUT;
      if (code == CODE_MAX_SCAN) begin
        s_d.scan = 1'b1;
        s_d.grp = '0;
        s_d.mem = '0;
        s_d.maxv = '0;
        s_d.per_seen = '0;
        s_d.st = S_SEEK;
      end else if (code == CODE_RESERVED) begin
        s_d.result = RESULT_RESERVED;
        s_d.done = 1'b1;
        s_d.st = S_IDLE;
      end else if (code >= CODE_FIRST_OUT && output_enable[code - CODE_FIRST_OUT]) begin
        s_d.on_prev = 1'b1;
        s_d.st = S_ARM;
      end else begin
        s_d.st = S_CONV;
      end
    end

    if (hit(psel, penable, pwrite, paddr, OFS_BLANK)) begin
      s_d.blank = pwdata[BLANK_W-1:0];
    end

    if (psel && !penable) begin
      s_d.prdata = rd_word(paddr, s_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s_q.prdata;
  // Zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign conv_sample = (s_q.st == S_CONV) && (s_q.cnt == '0);
  // Scan and output codes steer the mux from the output index in sel
  assign conv_channel = (s_q.scan || s_q.chan >= CODE_FIRST_OUT) ?
                        s_q.sel + CODE_FIRST_OUT : s_q.chan;
  assign adc_busy = (s_q.st != S_IDLE);
  assign conversion_done_flag = s_q.done;
  assign conversion_timing_error_flag = s_q.err;

endmodule : adc_sequencer_control

// >>> tb/adc_seq_checks_asserts.sv
// Purpose: Port assertions for adc_sequencer_control
// Assumes: Zero wait state APB
// Notes: Bound to the design below
`timescale 1ns/10ps
module adc_seq_checks
  import adc_seq_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic [adc_seq_pkg::NUM_OUT-1:0] output_enable, // Enables
  input wire logic conv_sample, // Sample
  input wire logic [adc_seq_pkg::CHAN_W-1:0] conv_channel, // Mux
  input wire logic adc_busy, // Busy
  input wire logic conversion_done_flag, // Done
  input wire logic conversion_timing_error_flag // Error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wc, rr, fc, dn, er, go, off;
  logic [4:0] c, code_q;
  assign c = pwdata[4:0];
  assign wc = psel & penable & pwrite & (paddr == OFS_CHAN);
  assign rr = psel & penable & !pwrite & (paddr == OFS_RESULT);
  assign fc = psel & penable & pwrite & (paddr == OFS_FCLR) & pwdata[FCLR_BIT];
  assign dn = conversion_done_flag;
  assign er = conversion_timing_error_flag;
  assign go = wc & !adc_busy & (c < CODE_MAX_SCAN);
  assign off = (c >= CODE_FIRST_OUT) && !output_enable[c - CODE_FIRST_OUT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= 5'h00;
    end else if (wc) begin
      code_q <= c;
    end
  end
  ////////////////////////////////////////
  AST_WR_CLR: assert property (wc && !adc_busy && c != CODE_RESERVED |=> !dn)
    else $error("done not cleared by select write");
  AST_START: assert property (go |=> conv_sample && conv_channel == $past(c))
    else $error("conversion did not start on selected code");
  AST_DONE_AT: assert property (go |-> ##200 !dn ##1 dn)
    else $error("done not set at conversion end");
  AST_RD_CLR: assert property (rr && dn && !adc_busy && code_q != CODE_RESERVED
    |=> !dn && adc_busy)
    else $error("result read did not clear done and restart");
  AST_RSV: assert property (wc && c == CODE_RESERVED |=> dn && !adc_busy)
    else $error("reserved code not finished at once");
  AST_HOLD: assert property (dn && !wc && !rr |=> dn)
    else $error("done dropped without host action");
  AST_PULSE: assert property (conv_sample |=> !conv_sample)
    else $error("sample pulse too long");
  AST_OFF: assert property (wc && !adc_busy && off |=> conv_sample)
    else $error("disabled output not sampled at once");
  AST_BLANK: assert property (wc && !adc_busy && c >= CODE_FIRST_OUT && !off
    |=> !conv_sample [*8])
    else $error("enabled output sampled before blanking");
  AST_FCLR: assert property (fc && !adc_busy |=> !er)
    else $error("fault clear did not clear error");
  AST_ABORT: assert property ($rose(er) |-> !adc_busy && !dn)
    else $error("abort left sequencer active");
  cover property (wc && c == CODE_MAX_SCAN);
  cover property ($rose(er));
  cover property (rr && dn);
endmodule : adc_seq_checks

bind adc_sequencer_control adc_seq_checks u_checks (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .output_enable(output_enable), .conv_sample(conv_sample), .conv_channel(conv_channel),
  .adc_busy(adc_busy), .conversion_done_flag(conversion_done_flag),
  .conversion_timing_error_flag(conversion_timing_error_flag));

// >>> tb/pwm_adc_model.sv
// Purpose: Dimming generator and converter stand-in
// Assumes: All outputs switch together
// Notes: Result encodes the mux code so a maximum is traceable
`timescale 1ns/10ps
module pwm_adc_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic run, // Dimming active
  input wire logic [15:0] period, // Period in cycles
  input wire logic [15:0] on_len, // On time in cycles
  input wire logic [4:0] conv_channel, // Mux code
  output logic [23:0] current_output, // On state
  output logic dim_period_start, // Period start pulse
  output logic [7:0] conv_data // Result
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (!run || cnt_q == period - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // Pulse outlasts blanking plus three conversions; on_len at the period gives full duty
  assign current_output = {24{run && cnt_q < on_len}};
  assign dim_period_start = run && cnt_q == 16'h0000;
  assign conv_data = {3'h2, conv_channel};
endmodule : pwm_adc_model

// >>> tb/adc_sequencer_control_bench.sv
// Purpose: Self-checking bench for adc_sequencer_control
// Assumes: Zero wait state APB
// Notes: Manual, output, scan and timing fault runs
`timescale 1ns/10ps
module adc_sequencer_control_bench;
  import adc_seq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [7:0] paddr = 8'h00, cdata;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, slv, dim, smp, busy, done, err;
  logic [23:0] oe = 24'h7FF1FF, cur;
  logic [4:0] chan;
  logic [15:0] per = 16'h03E8, onl = 16'h0320;
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  adc_sequencer_control u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .output_enable(oe), .current_output(cur), .dim_period_start(dim),
    .conv_data(cdata), .conv_sample(smp), .conv_channel(chan), .adc_busy(busy),
    .conversion_done_flag(done), .conversion_timing_error_flag(err));
  pwm_adc_model u_model (.clk(clk), .rst(rst), .run(run), .period(per), .on_len(onl),
    .conv_channel(chan), .current_output(cur), .dim_period_start(dim), .conv_data(cdata));
  task report_and_stop;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_flag(input int lim);
    int i;
    i = 0;
    n = 0;
    do begin
      @(posedge clk);
      if (dim === 1'b1) n++;
      i++;
    end while (i < lim && done !== 1'b1 && err !== 1'b1);
  endtask : wait_flag
  ////////////////////////////////////////
  task t_regs;
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check({rd[30:0], slv}, 32'h1);
    apb(1'b1, OFS_BLANK, 32'hFFFFFFFF);
    apb(1'b0, OFS_BLANK, 32'h0);
    check(rd, 32'hF);
    apb(1'b1, OFS_BLANK, 32'h0);
  endtask : t_regs
  task t_manual;
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      apb(1'b1, OFS_CHAN, 32'(c));
      wait_flag(300);
      apb(1'b0, OFS_RESULT, 32'h0);
      check(rd, c == 7 ? 32'h0 : 32'h40 | 32'(c));
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd, c == 7 ? 32'h1 : 32'h4);
      wait_flag(300);
    end
  endtask : t_manual
  task t_output;
    run <= 1'b1;
    repeat (1000) @(posedge clk);
    apb(1'b1, OFS_CHAN, 32'h11);
    wait_flag(300);
    apb(1'b0, OFS_RESULT, 32'h0);
    check(rd, 32'h51);
    wait_flag(300);
    apb(1'b1, OFS_CHAN, 32'h10);
    wait_flag(1500);
    apb(1'b0, OFS_RESULT, 32'h0);
    check(rd, 32'h50);
  endtask : t_output
  task t_scan;
    apb(1'b1, OFS_CHAN, 32'h06);
    wait_flag(12000);
    check({31'h0, done}, 32'h1);
    check({31'h0, n >= 9}, 32'h1);
    apb(1'b0, OFS_RESULT, 32'h0);
    check(rd, 32'h5E);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h4);
    wait_flag(12000);
    apb(1'b1, OFS_CHAN, 32'h06);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h4);
  endtask : t_scan
  task t_error;
    run <= 1'b0;
    per <= 16'h0190;
    onl <= 16'h0190;
    @(posedge clk);
    run <= 1'b1;
    wait_flag(1500);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, OFS_FCLR, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
  endtask : t_error
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_manual();
    t_output();
    t_scan();
    t_error();
    report_and_stop();
  end
endmodule : adc_sequencer_control_bench
